// file: rtl/aalu_core.sv
`timescale 1ns/1ns
// Contract
// - Add immediate adds the 8-bit literal to the working register, result to it.
// - Add with carry sums working register, file register and carry, to destination.
// - Dest bit 0 writes working register, 1 the file; access bit 0 forces access bank.
// - And immediate ANDs working register with the 8-bit literal into working register.
// - And immediate is upper byte 0000 1011, literal in the low eight bits.
// - And immediate changes only negative and zero flags.
// - Each operation is one word, four cycles: decode, read, process, write.
`include "aalu_defs.svh"

module aalu_core
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Instruction from decoder
  input  wire aalu_pkg::aalu_instr_t  instr,
  output logic                        instrReady,
  output logic                        instrDone,
  // Data memory
  output aalu_pkg::aalu_mem_req_t     memReq,
  input  wire logic [7:0]             memRdData,
  // Register port
  input  wire aalu_pkg::aalu_reg_req_t regReq,
  output logic [7:0]                  regRdData
);
  import aalu_pkg::*;

  aalu_state_t st;
  aalu_state_t next_st;

  // Sum of two bytes and a carry in, with flags
  function automatic logic [12:0] addFlags
  (
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       cin
  );
    logic [8:0] sum;
    logic [4:0] nib;
    logic [4:0] fl;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    fl = 5'h00;
    fl[`AALU_FLAG_C]      = sum[8];
    fl[`AALU_FLAG_DCARRY] = nib[4];
    fl[`AALU_FLAG_Z]      = (sum[7:0] == 8'h00);
    fl[`AALU_FLAG_OVFL]   = (a[7] == b[7]) && (sum[7] != a[7]);
    fl[`AALU_FLAG_N]      = sum[7];
    return {fl, sum[7:0]};
  endfunction

  // Classify an instruction word
  function automatic aalu_op_t decodeOp
  (
    input logic [15:0] word
  );
    aalu_op_t op;
    op = OP_NONE;
    if (word[15:8] == `AALU_OPC_ADDI)
    begin
      op = OP_ADDI;
    end
    else if (word[15:8] == `AALU_OPC_ANDI)
    begin
      op = OP_ANDI;
    end
    else if (word[15:10] == `AALU_OPC_ADDF)
    begin
      op = OP_ADDF;
    end
    else if (word[15:10] == `AALU_OPC_ADDFC)
    begin
      op = OP_ADDFC;
    end
    return op;
  endfunction

  // True for the two file-register additions
  function automatic logic isFileOp
  (
    input aalu_op_t op
  );
    return (op == OP_ADDF) || (op == OP_ADDFC);
  endfunction

  // Full data address from file field, access bit and bank
  function automatic logic [11:0] fileAddr
  (
    input logic [7:0] f,
    input logic       acc,
    input logic [3:0] bank
  );
    logic [3:0] b;
    b = bank;
    if (!acc)
    begin
      b = (f < `AALU_ACC_SPLIT) ? `AALU_ACC_LOW_BANK : `AALU_ACC_HIGH_BANK;
    end
    return {b, f};
  endfunction

  // Register read mux
  function automatic logic [7:0] readReg
  (
    input aalu_state_t s,
    input logic [3:0]  addr
  );
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      `AALU_REG_WORK:
        d = s.work;
      `AALU_REG_FLAGS:
        d = {3'h0, s.flags};
      `AALU_REG_BANK:
        d = {4'h0, s.bank};
      `AALU_REG_INFO:
      begin
        d[`AALU_INFO_UNSUP] = s.unsup;
        d[`AALU_INFO_BUSY]  = (s.phase != PH_DECODE);
      end
      default:
        d = 8'h00;
    endcase
    return d;
  endfunction

  always_comb
  begin
    logic [12:0] addRes;
    logic        carryIn;
    logic [7:0]  operand;
    addRes = 13'h0000;
    carryIn = 1'b0;
    operand = 8'h00;
    next_st = st;
    next_st.done = 1'b0;
    next_st.mem.rdEn = 1'b0;
    next_st.mem.wrEn = 1'b0;
    next_st.rdData = 8'h00;

    // Software writes; the core write in the write phase overrides below
    if (regReq.wr)
    begin
      unique case (regReq.addr)
        `AALU_REG_WORK:
          next_st.work = regReq.wrData;
        `AALU_REG_FLAGS:
          next_st.flags = regReq.wrData[4:0];
        `AALU_REG_BANK:
          next_st.bank = regReq.wrData[3:0];
        `AALU_REG_INFO:
          if (regReq.wrData[`AALU_INFO_UNSUP])
          begin
            next_st.unsup = 1'b0;
          end
        default:
          next_st.unsup = next_st.unsup;
      endcase
    end

    unique case (st.phase)
      PH_DECODE:
      begin
        if (instr.valid)
        begin
          next_st.op = decodeOp(instr.word);
          next_st.literal = instr.word[7:0];
          next_st.destFile = instr.word[`AALU_DEST_BIT];
          next_st.mem.addr = fileAddr(instr.word[7:0], instr.word[`AALU_ACC_BIT],
                                      next_st.bank);
          next_st.mem.rdEn = isFileOp(next_st.op);
          if (next_st.op == OP_NONE)
          begin
            next_st.unsup = 1'b1;
          end
          next_st.phase = PH_READ;
          next_st.instrReady = 1'b0;
        end
      end
      PH_READ:
      begin
        next_st.phase = PH_PROCESS;
      end
      PH_PROCESS:
      begin
        operand = isFileOp(st.op) ? memRdData : st.literal;
        carryIn = (st.op == OP_ADDFC) ? st.flags[`AALU_FLAG_C] : 1'b0;
        addRes = addFlags(st.work, operand, carryIn);
        next_st.resFlags = st.flags;
        unique case (st.op)
          OP_ADDI, OP_ADDF, OP_ADDFC:
          begin
            next_st.result = addRes[7:0];
            next_st.resFlags = addRes[12:8];
          end
          OP_ANDI:
          begin
            next_st.result = st.work & st.literal;
            next_st.resFlags[`AALU_FLAG_Z] = (next_st.result == 8'h00);
            next_st.resFlags[`AALU_FLAG_N] = next_st.result[7];
          end
          default:
            next_st.result = st.work;
        endcase
        next_st.mem.wrData = next_st.result;
        next_st.mem.wrEn = st.destFile && isFileOp(st.op);
        next_st.done = 1'b1;
        next_st.phase = PH_WRITE;
      end
      PH_WRITE:
      begin
        if (st.op != OP_NONE)
        begin
          next_st.flags = st.resFlags;
          if (!st.mem.wrEn)
          begin
            next_st.work = st.result;
          end
        end
        next_st.phase = PH_DECODE;
        next_st.instrReady = 1'b1;
      end
    endcase

    if (regReq.rd)
    begin
      next_st.rdData = readReg(st, regReq.addr);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st.phase       <= PH_DECODE;
      st.instrReady  <= 1'b1;
      st.op          <= OP_NONE;
      st.literal     <= 8'h00;
      st.destFile    <= 1'b0;
      st.mem.addr    <= `AALU_ADDR_RST;
      st.mem.rdEn    <= 1'b0;
      st.mem.wrEn    <= 1'b0;
      st.mem.wrData  <= 8'h00;
      st.result      <= 8'h00;
      st.resFlags    <= `AALU_FLAGS_RST;
      st.work        <= `AALU_WORK_RST;
      st.flags       <= `AALU_FLAGS_RST;
      st.bank        <= `AALU_BANK_RST;
      st.unsup       <= 1'b0;
      st.done        <= 1'b0;
      st.rdData      <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign instrReady = st.instrReady;
  assign instrDone  = st.done;
  assign memReq     = st.mem;
  assign regRdData  = st.rdData;

endmodule

// file: rtl/aalu_defs.svh
`ifndef AALU_DEFS_SVH
`define AALU_DEFS_SVH

// Register offsets on the plain register port
`define AALU_REG_WORK      4'h0
`define AALU_REG_FLAGS     4'h1
`define AALU_REG_BANK      4'h2
`define AALU_REG_INFO      4'h3

// Flag positions in the flag register
`define AALU_FLAG_C        0
`define AALU_FLAG_DCARRY   1
`define AALU_FLAG_Z        2
`define AALU_FLAG_OVFL     3
`define AALU_FLAG_N        4

// Info register positions
`define AALU_INFO_UNSUP    0
`define AALU_INFO_BUSY     1

// Reset values
`define AALU_WORK_RST      8'h00
`define AALU_FLAGS_RST     5'h00
`define AALU_BANK_RST      4'h0
`define AALU_ADDR_RST      12'h000

// Instruction word fields and encodings
`define AALU_DEST_BIT      9
`define AALU_ACC_BIT       8
`define AALU_OPC_ADDI      8'h0F
`define AALU_OPC_ANDI      8'h0B
`define AALU_OPC_ADDF      6'h09
`define AALU_OPC_ADDFC     6'h08

// Access bank mapping
`define AALU_ACC_SPLIT     8'h80
`define AALU_ACC_LOW_BANK  4'h0
`define AALU_ACC_HIGH_BANK 4'hF

`endif

// file: rtl/aalu_pkg.sv
package aalu_pkg;

  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } aalu_phase_t;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_ADDI  = 3'b001,
    OP_ADDF  = 3'b010,
    OP_ADDFC = 3'b011,
    OP_ANDI  = 3'b100
  } aalu_op_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } aalu_instr_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        rdEn;
    logic        wrEn;
    logic [7:0]  wrData;
  } aalu_mem_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } aalu_reg_req_t;

  typedef struct packed {
    aalu_phase_t   phase;
    logic          instrReady;
    aalu_op_t      op;
    logic [7:0]    literal;
    logic          destFile;
    aalu_mem_req_t mem;
    logic [7:0]    result;
    logic [4:0]    resFlags;
    logic [7:0]    work;
    logic [4:0]    flags;
    logic [3:0]    bank;
    logic          unsup;
    logic          done;
    logic [7:0]    rdData;
  } aalu_state_t;

endpackage

// file: test/aalu_mem_model.sv
`timescale 1ns/1ns
module aalu_mem_model
(
  // Clock
  input wire logic                    ref_clk,
  // Memory port
  input wire aalu_pkg::aalu_mem_req_t memReq,
  output logic [7:0]                  memRdData
);
  import aalu_pkg::*;
  logic [7:0] mem [4096];
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = i[7:0];
    // Distinct byte in bank 3 so the bank select shows
    mem[12'h305] = 8'h5A;
  end
  // Byte one cycle after the read strobe, changing junk otherwise
  always @(posedge ref_clk)
  begin
    if (memReq.wrEn)
      mem[memReq.addr] <= memReq.wrData;
    memRdData <= memReq.rdEn ? mem[memReq.addr] : ~memRdData;
  end
endmodule

// file: test/aalu_core_assertions.sv
`timescale 1ns/1ns
module aalu_core_assertions
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst,
  // Core ports
  input wire aalu_pkg::aalu_instr_t   instr,
  input wire logic                    instrReady,
  input wire logic                    instrDone,
  input wire aalu_pkg::aalu_mem_req_t memReq,
  input wire logic [7:0]              regRdData,
  input wire aalu_pkg::aalu_reg_req_t regReq
);
  import aalu_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic        tk;
  logic        fop;
  logic [15:0] lastW;
  assign tk = instrReady && instr.valid;
  assign fop = instr.word[15:11] == 5'h04;
  always_ff @(posedge ref_clk)
    lastW <= instr.word;
  property p_busy; tk |=> !instrReady [*3] ##1 instrReady; endproperty
  a_busy: assert property (p_busy) else $error("ready timing");
  property p_done; tk |=> !instrDone [*2] ##1 instrDone; endproperty
  a_done: assert property (p_done) else $error("done timing");
  property p_rd; tk && fop |=> memReq.rdEn; endproperty
  a_rd: assert property (p_rd) else $error("no operand read");
  property p_lit; tk && instr.word[15:12] == 4'h0 |=> !memReq.rdEn [*3]; endproperty
  a_lit: assert property (p_lit) else $error("literal op read");
  property p_wr1; tk && fop && instr.word[9] |-> ##3 memReq.wrEn; endproperty
  a_wr1: assert property (p_wr1) else $error("file not written");
  property p_wr0; tk && !(fop && instr.word[9]) |-> ##3 !memReq.wrEn; endproperty
  a_wr0: assert property (p_wr0) else $error("stray file write");
  property p_addr; tk && fop |=> memReq.addr[7:0] == lastW[7:0]
    && (lastW[8] || memReq.addr[11:8] == {4{lastW[7]}}); endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_pair; memReq.rdEn |-> ##2 instrDone && !memReq.rdEn; endproperty
  a_pair: assert property (p_pair) else $error("read not paired");
  property p_regq; !regReq.rd |=> regRdData == 8'h00; endproperty
  a_regq: assert property (p_regq) else $error("read data idle");
endmodule

bind aalu_core aalu_core_assertions aalu_core_assertions_i
(
  .ref_clk, .rst, .instr, .instrReady, .instrDone, .memReq, .regRdData, .regReq
);

// file: test/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  import aalu_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [7:0]  ew;
    logic [4:0]  ef;
  } aalu_row_t;
  logic          ref_clk;
  logic          rst;
  aalu_instr_t   instr;
  logic          instrReady;
  logic          instrDone;
  aalu_mem_req_t memReq;
  logic [7:0]    memRdData;
  aalu_reg_req_t regReq;
  logic [7:0]    regRdData;
  int            n_errors = 0;
  int            checks = 0;
  int            cyc = 0;
  aalu_row_t     rows [12] = '{
    '{16'h0F10, 8'h10, 5'h00}, '{16'h0F15, 8'h25, 5'h00},
    '{16'h0F7E, 8'hA3, 5'h1A}, '{16'h0B5F, 8'h03, 5'h0A},
    '{16'h0B00, 8'h00, 5'h0E}, '{16'h24C2, 8'hC2, 5'h10},
    '{16'h2617, 8'hC2, 5'h10}, '{16'h0F40, 8'h02, 5'h01},
    '{16'h2002, 8'h05, 5'h00}, '{16'h0FFB, 8'h00, 5'h07},
    '{16'h2330, 8'h00, 5'h00}, '{16'h0900, 8'h00, 5'h00}};

  aalu_core aalu_core_i (.ref_clk, .rst, .instr, .instrReady, .instrDone, .memReq,
    .memRdData, .regReq, .regRdData);
  aalu_mem_model aalu_mem_model_i (.ref_clk, .memReq, .memRdData);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report;
  begin
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_errors++;
      final_report;
    end
  end

  task automatic exec(input logic [15:0] w);
  begin
    instr <= '{1'b1, w};
    @(posedge ref_clk);
    instr.valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
  begin
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
    @(posedge ref_clk);
  end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
  begin
    regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    @(negedge ref_clk);
    `CHK("reg", e, regRdData)
    @(posedge ref_clk);
  end
  endtask

  initial
  begin
    rst = 1'b1;
    instr = '0;
    regReq = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("ready", 1'b1, instrReady)
    rdchk(4'h0, 8'h00);
    rdchk(4'h1, 8'h00);
    rdchk(4'h2, 8'h00);
    foreach (rows[i])
    begin
      exec(rows[i].w);
      rdchk(4'h0, rows[i].ew);
      rdchk(4'h1, {3'b000, rows[i].ef});
    end
    `CHK("mem", 8'hD9, aalu_mem_model_i.mem[12'h017])
    `CHK("mem", 8'h31, aalu_mem_model_i.mem[12'h030])
    rdchk(4'h3, 8'h01);
    wr(4'h3, 8'h01);
    rdchk(4'h3, 8'h00);
    wr(4'h9, 8'hFF);
    rdchk(4'h9, 8'h00);
    wr(4'h2, 8'h03);
    rdchk(4'h2, 8'h03);
    exec(16'h2505);
    rdchk(4'h0, 8'h5A);
    exec(16'h2405);
    rdchk(4'h0, 8'h5F);
    exec(16'h0B0F);
    exec(16'h0F01);
    rdchk(4'h0, 8'h10);
    rdchk(4'h1, 8'h02);
    instr <= '{1'b1, 16'h0F01};
    @(posedge ref_clk);
    instr.valid <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("ready", 1'b1, instrReady)
    rdchk(4'h0, 8'h00);
    rdchk(4'h2, 8'h00);
    final_report;
  end
endmodule
